// ==== pkg/eerx_defs.svh ====
/*
 * Offsets, field positions, reset values and timing counts of the
 * receive low power idle decoder.
 * Assumes a 100 MHz core clock and byte addresses on an 8-bit port.
 */
`ifndef EERX_DEFS_SVH
`define EERX_DEFS_SVH

// Register byte offsets
`define EERX_ADDR_CTRL       8'h00
`define EERX_ADDR_STATUS     8'h04
`define EERX_ADDR_MASK       8'h08
`define EERX_ADDR_TRANS      8'h0C
`define EERX_ADDR_TIME       8'h10
`define EERX_ADDR_STATE      8'h14

// Control fields
`define EERX_CTRL_EE_EN      0
`define EERX_CTRL_RX_EN      1
`define EERX_CTRL_WAKE_EN    2
`define EERX_CTRL_EWAKE_EN   3
`define EERX_CTRL_W          4
`define EERX_CTRL_RST        4'h0

// Status and mask fields
`define EERX_ST_ENTRY        0
`define EERX_ST_WAKE         1
`define EERX_ST_EWAKE        2
`define EERX_ST_W            3
`define EERX_STATUS_RST      3'h0
`define EERX_MASK_RST        3'h0

// State register fields
`define EERX_SS_DECODE       0
`define EERX_SS_LPI          1
`define EERX_SS_LINK         2

// Receive LPI code on the byte interface
`define EERX_LPI_RXD         8'h01

// Filter lengths in receive clocks
`define EERX_LPI_ON_SAMPLES  3'h3
`define EERX_LPI_OFF_SAMPLES 3'h4

// Timing
`define EERX_CORE_CLK_MHZ    100
`define EERX_LINK_STABLE_S   1
`define EERX_TIME_UNIT_US    1
`define EERX_US_CYCLES       (`EERX_TIME_UNIT_US * `EERX_CORE_CLK_MHZ)
`define EERX_LINK_CYCLES     \
    (`EERX_LINK_STABLE_S * 1000000 * `EERX_CORE_CLK_MHZ)

`endif

// ==== pkg/eerx_pkg.sv ====
/*
 * Types of the receive low power idle decoder.
 * Assumes nothing of its surroundings.
 */
package eerx_pkg;

    typedef enum logic [0:0]
    {
        FLT_INACTIVE = 1'b0,
        FLT_ACTIVE   = 1'b1
    } eerx_flt_state_t;

    typedef enum logic [1:0]
    {
        SPD_10   = 2'b00,
        SPD_100  = 2'b01,
        SPD_1000 = 2'b10
    } eerx_speed_t;

endpackage : eerx_pkg

// ==== rtl/eerx_lpi_filter.sv ====
/*
 * Run-length filter for the receive LPI indication, one sample per
 * receive clock edge seen by the core clock.
 * Assumes samples and strobe are already in the core clock domain.
 */
`timescale 1ns/100ps
`include "eerx_defs.svh"

module eerx_lpi_filter
    import eerx_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Sampled indication
    input  wire logic sample_stb,
    input  wire logic lpi_sample,
    input  wire logic enable,
    // Filtered result
    output logic      lpi_valid,
    output logic      lpi_rise,
    output logic      lpi_fall
);

    eerx_flt_state_t state_reg;
    eerx_flt_state_t state_next;
    logic [2:0]      run_reg;
    logic [2:0]      run_next;
    logic            rise_reg;
    logic            fall_reg;
    wire logic       opposite;
    wire logic [2:0] need;
    wire logic       flip;

    ////////////////////////////////////////////////////////////////////
    // Decision
    assign opposite = (state_reg == FLT_ACTIVE) ? !lpi_sample : lpi_sample;
    assign need     = (state_reg == FLT_ACTIVE)
                    ? `EERX_LPI_OFF_SAMPLES - 3'h1
                    : `EERX_LPI_ON_SAMPLES - 3'h1;
    assign flip     = enable && sample_stb && opposite && run_reg == need;

    always_comb
    begin
        state_next = state_reg;
        run_next   = run_reg;
        if (sample_stb)
        begin
            run_next = opposite ? run_reg + 3'h1 : 3'h0;
        end
        if (flip)
        begin
            run_next = 3'h0;
            unique case (state_reg)
                FLT_INACTIVE: state_next = FLT_ACTIVE;
                FLT_ACTIVE:   state_next = FLT_INACTIVE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State
    always_ff @(posedge core_clk)
    begin
        if (reset || !enable)
        begin
            state_reg <= FLT_INACTIVE;
            run_reg   <= 3'h0;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            run_reg   <= run_next;
            rise_reg  <= flip && state_reg == FLT_INACTIVE;
            fall_reg  <= flip && state_reg == FLT_ACTIVE;
        end
    end

    assign lpi_valid = (state_reg == FLT_ACTIVE);
    assign lpi_rise  = rise_reg;
    assign lpi_fall  = fall_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_FLT_ON: assert property (
        enable && state_reg == FLT_INACTIVE && sample_stb && lpi_sample
        && run_reg == 3'h2 ##1 enable |-> lpi_valid)
        else $error("LPI not valid after three active samples");
    AST_FLT_OFF_HOLD: assert property (
        enable && lpi_valid && sample_stb && !lpi_sample
        && run_reg < 3'h3 ##1 enable |-> lpi_valid)
        else $error("LPI dropped before four inactive samples");
    CVR_FLT_FALL: cover property (lpi_fall);

endmodule : eerx_lpi_filter

// ==== rtl/eerx_rx_lpi_decoder.sv ====
/*
 * Receive low power idle decoder: samples the byte receive interface,
 * filters the LPI code, raises entry and wake flags, interrupt and
 * remote wake, and keeps transition and time counters.
 * Assumes a plain register port in the core clock domain and PHY pins
 * that are asynchronous to the core clock, with rx_clk below 50 MHz.
 */
// Local design decisions: the address map and strobed register access.
// Function
// - LPI valid after 3 on, 4 off clocks
// - LPI start sets entry flag
// - Entry flag interrupts only when enabled
// - LPI end sets wake flag if enabled
// - Wake flag sets energy wake status
// - Energy wake status wakes host when enabled
// - Wake works in suspend, no power gating
// - No hardware wake to power mapping
// - Decode only when enabled, fast, full, agreed
// - Decode only after one second link up
// - Decode ignores receiver enable bit
// - Count LPI off-to-on transitions
// - Count LPI time in microseconds
// - Counters read-only, unchanged by reads
// - Counters run in all power states
`timescale 1ns/100ps
`include "eerx_defs.svh"

module eerx_rx_lpi_decoder
    import eerx_pkg::*;
#(
    parameter int unsigned LINK_STABLE_CYCLES = `EERX_LINK_CYCLES
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Receive byte interface
    input  wire logic        rx_clk,
    input  wire logic [7:0]  rxd,
    input  wire logic        rx_dv,
    input  wire logic        rx_er,
    // Link status
    input  wire logic        link_up,
    input  wire logic [1:0]  link_speed,
    input  wire logic        link_full_duplex,
    input  wire logic        eee_agreed,
    // Events and state out
    output logic             irq,
    output logic             remote_wake,
    output logic             receiver_enable,
    output logic             lpi_active
);

    localparam int PIN_W = 16;
    localparam logic [6:0] US_LAST = 7'(`EERX_US_CYCLES - 1);
    localparam logic [26:0] LINK_LAST = 27'(LINK_STABLE_CYCLES);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0]      pin_s1_reg;
    logic [PIN_W-1:0]      pin_s2_reg;
    logic                  rx_clk_d3_reg;

    assign pin_raw = {rx_clk, rx_dv, rx_er, rxd, link_up, link_speed,
                      link_full_duplex, eee_agreed};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++)
        begin : g_sync
            always_ff @(posedge core_clk)
            begin
                if (reset)
                begin
                    pin_s1_reg[gi] <= 1'b0;
                    pin_s2_reg[gi] <= 1'b0;
                end
                else
                begin
                    pin_s1_reg[gi] <= pin_raw[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (reset)
            rx_clk_d3_reg <= 1'b0;
        else
            rx_clk_d3_reg <= pin_s2_reg[15];
    end

    wire logic       rx_clk_s;
    wire logic       rx_dv_s;
    wire logic       rx_er_s;
    wire logic [7:0] rxd_s;
    wire logic       link_up_s;
    wire logic [1:0] speed_s;
    wire logic       full_s;
    wire logic       agreed_s;
    wire logic       rx_edge;
    wire logic       lpi_code;

    assign rx_clk_s  = pin_s2_reg[15];
    assign rx_dv_s   = pin_s2_reg[14];
    assign rx_er_s   = pin_s2_reg[13];
    assign rxd_s     = pin_s2_reg[12:5];
    assign link_up_s = pin_s2_reg[4];
    assign speed_s   = pin_s2_reg[3:2];
    assign full_s    = pin_s2_reg[1];
    assign agreed_s  = pin_s2_reg[0];
    assign rx_edge   = rx_clk_s && !rx_clk_d3_reg;
    assign lpi_code  = !rx_dv_s && rx_er_s && rxd_s == `EERX_LPI_RXD;

    ////////////////////////////////////////////////////////////////////
    // Link stability timer
    logic [26:0] link_cnt_reg;
    wire logic   link_stable;

    assign link_stable = (link_cnt_reg == LINK_LAST);

    always_ff @(posedge core_clk)
    begin
        if (reset || !link_up_s)
            link_cnt_reg <= 27'h0;
        else if (!link_stable)
            link_cnt_reg <= link_cnt_reg + 27'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [`EERX_CTRL_W-1:0] ctrl_reg;
    logic [`EERX_ST_W-1:0]   status_reg;
    logic [`EERX_ST_W-1:0]   status_next;
    logic [`EERX_ST_W-1:0]   mask_reg;
    logic [31:0]             trans_reg;
    logic [31:0]             time_reg;
    logic [6:0]              us_cnt_reg;
    logic [31:0]             rdata_reg;
    logic                    decode_reg;

    wire logic               wr_ctrl;
    wire logic               wr_status;
    wire logic               wr_mask;
    wire logic               speed_ok;
    wire logic               decode_ok;
    wire logic               lpi_valid;
    wire logic               lpi_rise;
    wire logic               lpi_fall;
    wire logic               wake_set;
    wire logic               us_tick;
    wire logic [`EERX_ST_W-1:0] status_set;
    wire logic [`EERX_ST_W-1:0] status_clr;
    wire logic [31:0]        rd_mux;

    assign wr_ctrl   = reg_wr && reg_addr == `EERX_ADDR_CTRL;
    assign wr_status = reg_wr && reg_addr == `EERX_ADDR_STATUS;
    assign wr_mask   = reg_wr && reg_addr == `EERX_ADDR_MASK;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            ctrl_reg <= `EERX_CTRL_RST;
        else if (wr_ctrl)
            ctrl_reg <= reg_wdata[`EERX_CTRL_W-1:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            mask_reg <= `EERX_MASK_RST;
        else if (wr_mask)
            mask_reg <= reg_wdata[`EERX_ST_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Decode enable; receiver enable plays no part
    assign speed_ok  = speed_s == SPD_100 || speed_s == SPD_1000;
    assign decode_ok = ctrl_reg[`EERX_CTRL_EE_EN] && speed_ok && full_s
                     && agreed_s && link_stable;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            decode_reg <= 1'b0;
        else
            decode_reg <= decode_ok;
    end

    eerx_lpi_filter u_filter
    (
        .core_clk   (core_clk),
        .reset      (reset),
        .sample_stb (rx_edge),
        .lpi_sample (lpi_code),
        .enable     (decode_reg),
        .lpi_valid  (lpi_valid),
        .lpi_rise   (lpi_rise),
        .lpi_fall   (lpi_fall)
    );

    ////////////////////////////////////////////////////////////////////
    // Sticky flags, set wins over clear, no power state gating
    assign wake_set   = lpi_fall
                      && ctrl_reg[`EERX_CTRL_WAKE_EN];
    assign status_set = {wake_set, wake_set, lpi_rise};
    assign status_clr = wr_status ? reg_wdata[`EERX_ST_W-1:0] : 3'h0;

    always_comb
    begin
        status_next = (status_reg & ~status_clr) | status_set;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            status_reg <= `EERX_STATUS_RST;
        else
            status_reg <= status_next;
    end

    assign irq = |(status_reg & mask_reg);
    assign remote_wake = status_reg[`EERX_ST_EWAKE]
                       && ctrl_reg[`EERX_CTRL_EWAKE_EN];
    assign receiver_enable = ctrl_reg[`EERX_CTRL_RX_EN];
    assign lpi_active = lpi_valid;

    ////////////////////////////////////////////////////////////////////
    // Counters, read-only, no power state gating
    assign us_tick = lpi_valid && us_cnt_reg == US_LAST;

    always_ff @(posedge core_clk)
    begin
        if (reset || !lpi_valid)
            us_cnt_reg <= 7'h0;
        else if (us_tick)
            us_cnt_reg <= 7'h0;
        else
            us_cnt_reg <= us_cnt_reg + 7'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            trans_reg <= 32'h0;
        else if (lpi_rise)
            trans_reg <= trans_reg + 32'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            time_reg <= 32'h0;
        else if (us_tick)
            time_reg <= time_reg + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // Read port, data in the cycle after the strobe only
    assign rd_mux =
        reg_addr == `EERX_ADDR_CTRL   ? {28'h0, ctrl_reg}   :
        reg_addr == `EERX_ADDR_STATUS ? {29'h0, status_reg} :
        reg_addr == `EERX_ADDR_MASK   ? {29'h0, mask_reg}   :
        reg_addr == `EERX_ADDR_TRANS  ? trans_reg           :
        reg_addr == `EERX_ADDR_TIME   ? time_reg            :
        reg_addr == `EERX_ADDR_STATE  ?
            {29'h0, link_stable, lpi_valid, decode_reg}     :
        32'h0;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            rdata_reg <= 32'h0;
        else
            rdata_reg <= reg_rd ? rd_mux : 32'h0;
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_ENTRY_SET: assert property (lpi_rise |=> status_reg[0])
        else $error("Entry flag not set on LPI start");
    AST_IRQ_GATE: assert property (
        irq |-> (status_reg[0] && mask_reg[0]) || (status_reg[1]
        && mask_reg[1]) || (status_reg[2] && mask_reg[2]))
        else $error("Interrupt without unmasked flag");
    AST_IRQ_ENTRY: assert property (
        lpi_rise && mask_reg[0] ##1 mask_reg[0] |-> irq)
        else $error("Enabled entry flag gave no interrupt");
    AST_WAKE_SET: assert property (
        lpi_fall && ctrl_reg[2] |=> status_reg[1])
        else $error("Wake flag not set on LPI end");
    AST_WAKE_BLOCK: assert property (
        $rose(status_reg[1]) |-> $past(ctrl_reg[2]) && $past(lpi_fall))
        else $error("Wake flag set while wake disabled");
    AST_EWAKE_FOLLOW: assert property (
        $rose(status_reg[1]) |-> status_reg[2])
        else $error("Energy wake status missed");
    AST_REMOTE: assert property (
        remote_wake |-> status_reg[2] && ctrl_reg[3])
        else $error("Remote wake without enable");
    AST_DECODE_GATE: assert property (
        lpi_valid |-> $past(decode_reg))
        else $error("LPI valid while decode disabled");
    AST_LINK_WAIT: assert property (
        decode_reg |-> $past(link_up_s, 2))
        else $error("Decode without stable link");
    AST_TRANS_INC: assert property (
        lpi_rise |=> trans_reg == $past(trans_reg) + 32'h1)
        else $error("Transition counter missed");
    AST_COUNT_RO: assert property (
        reg_wr && !lpi_rise && !us_tick |=>
        trans_reg == $past(trans_reg) && time_reg == $past(time_reg))
        else $error("Counter changed by access");
    AST_TIME_IDLE: assert property (
        !lpi_valid |=> time_reg == $past(time_reg))
        else $error("Time counted outside LPI");
    AST_STATUS_SETWINS: assert property (
        lpi_rise && wr_status && reg_wdata[0] |=> status_reg[0])
        else $error("Clear beat a new entry event");

    CVR_ENTRY: cover property (lpi_rise);
    CVR_WAKE: cover property (wake_set ##1 remote_wake);
    CVR_TICK: cover property (us_tick);
    CVR_READ_TRANS: cover property (reg_rd && reg_addr == `EERX_ADDR_TRANS);

endmodule : eerx_rx_lpi_decoder

// ==== test/eee_rx_lpi_decoder_tb.sv ====
/*
 * Self-checking bench of the receive LPI decoder.
 * Assumes the PHY model drives the receive pins on its own clock.
 */
`timescale 1ns/100ps
`include "eerx_defs.svh"

module eee_rx_lpi_decoder_tb
    import eerx_pkg::*;
;
    localparam int LINK = 200;

    logic        core_clk;
    logic        reset;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        rx_clk;
    logic [7:0]  rxd;
    logic        rx_dv;
    logic        rx_er;
    logic        link_up;
    logic [1:0]  link_speed;
    logic        link_full_duplex;
    logic        eee_agreed;
    logic        irq;
    logic        remote_wake;
    logic        receiver_enable;
    logic        lpi_active;
    logic [31:0] d;
    int          num_errors;
    int          compares;

    eerx_rx_lpi_decoder #(.LINK_STABLE_CYCLES(LINK)) dut
    (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv),
        .rx_er(rx_er), .link_up(link_up), .link_speed(link_speed),
        .link_full_duplex(link_full_duplex), .eee_agreed(eee_agreed),
        .irq(irq), .remote_wake(remote_wake),
        .receiver_enable(receiver_enable), .lpi_active(lpi_active)
    );

    eerx_phy_model phy
    (
        .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task chk(input string name, input logic [31:0] exp,
             input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        chk(name, v, d);
    endtask : rd_chk

    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge core_clk);
        #1 chk("rdata idle", 32'h0, reg_rdata);
    endtask : rd

    task set_link(input logic up, input logic [1:0] spd, input logic fd,
                  input logic ag);
        @(posedge core_clk);
        link_up          <= up;
        link_speed       <= spd;
        link_full_duplex <= fd;
        eee_agreed       <= ag;
        tick(4);
    endtask : set_link

    task wait_lpi(input logic v);
        int k;
        k = 0;
        while (lpi_active !== v && k < 200)
        begin
            tick(1);
            k++;
        end
        if (lpi_active !== v)
        begin
            chk("lpi_active", {31'h0, v}, {31'h0, lpi_active});
            finish_test();
        end
    endtask : wait_lpi

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk("ctrl", `EERX_ADDR_CTRL, 32'h0);
        rd_chk("mask", `EERX_ADDR_MASK, 32'h0);
        rd_chk("status", `EERX_ADDR_STATUS, 32'h0);
        rd_chk("trans", `EERX_ADDR_TRANS, 32'h0);
        rd_chk("time", `EERX_ADDR_TIME, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
    endtask : t_reset

    task t_blocked(input logic [31:0] c, input logic up, input logic [1:0] spd,
                   input logic fd, input logic ag, input int settle);
        wr(`EERX_ADDR_CTRL, c);
        set_link(up, spd, fd, ag);
        tick(settle);
        phy.send(1'b1, 9);
        tick(30);
        chk("lpi_active", 32'h0, {31'h0, lpi_active});
        rd_chk("status", `EERX_ADDR_STATUS, 32'h0);
        phy.send(1'b1, 1);
        phy.send(1'b0, 5);
    endtask : t_blocked

    task t_gating;
        t_blocked(32'h1, 1'b0, SPD_1000, 1'b1, 1'b1, 0);
        t_blocked(32'h1, 1'b1, SPD_1000, 1'b1, 1'b1, 0);
        t_blocked(32'h1, 1'b1, SPD_10, 1'b1, 1'b1, 0);
        t_blocked(32'h1, 1'b1, SPD_1000, 1'b0, 1'b1, 0);
        t_blocked(32'h1, 1'b1, SPD_1000, 1'b1, 1'b0, 0);
        t_blocked(32'h0, 1'b1, SPD_1000, 1'b1, 1'b1, LINK + 20);
    endtask : t_gating

    task t_entry;
        wr(`EERX_ADDR_CTRL, 32'h1);
        set_link(1'b1, SPD_100, 1'b1, 1'b1);
        tick(LINK + 20);
        chk("receiver_enable", 32'h0, {31'h0, receiver_enable});
        phy.send(1'b1, 2);
        phy.send(1'b0, 4);
        tick(30);
        chk("lpi_active", 32'h0, {31'h0, lpi_active});
        phy.send(1'b1, 9);
        wait_lpi(1'b1);
        tick(2);
        rd_chk("status", `EERX_ADDR_STATUS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`EERX_ADDR_MASK, 32'h1);
        tick(1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`EERX_ADDR_STATUS, 32'h1);
        tick(1);
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk("trans", `EERX_ADDR_TRANS, 32'h1);
        phy.send(1'b1, 1);
        phy.send(1'b0, 3);
        tick(40);
        chk("lpi_active", 32'h1, {31'h0, lpi_active});
        phy.send(1'b0, 1);
        wait_lpi(1'b0);
        tick(2);
        rd_chk("status", `EERX_ADDR_STATUS, 32'h0);
        chk("remote_wake", 32'h0, {31'h0, remote_wake});
    endtask : t_entry

    task t_wake;
        logic [31:0] t0;
        wr(`EERX_ADDR_CTRL, 32'hF);
        set_link(1'b1, SPD_1000, 1'b1, 1'b1);
        tick(LINK + 20);
        chk("receiver_enable", 32'h1, {31'h0, receiver_enable});
        rd(`EERX_ADDR_TIME);
        t0 = d;
        phy.send(1'b1, 9);
        wait_lpi(1'b1);
        tick(400);
        chk("lpi_active", 32'h1, {31'h0, lpi_active});
        phy.send(1'b1, 1);
        phy.send(1'b0, 4);
        wait_lpi(1'b0);
        tick(2);
        rd_chk("status", `EERX_ADDR_STATUS, 32'h7);
        chk("remote_wake", 32'h1, {31'h0, remote_wake});
        rd_chk("trans", `EERX_ADDR_TRANS, 32'h2);
        rd_chk("state", `EERX_ADDR_STATE, 32'h5);
        rd(`EERX_ADDR_TIME);
        chk("time", 32'h5, d - t0);
        wr(`EERX_ADDR_TIME, 32'hFF);
        wr(`EERX_ADDR_TRANS, 32'h0);
        rd_chk("time", `EERX_ADDR_TIME, d);
        rd_chk("trans", `EERX_ADDR_TRANS, 32'h2);
        wr(`EERX_ADDR_CTRL, 32'h7);
        tick(1);
        chk("remote_wake", 32'h0, {31'h0, remote_wake});
        wr(`EERX_ADDR_STATUS, 32'h7);
        rd_chk("status", `EERX_ADDR_STATUS, 32'h0);
    endtask : t_wake

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        num_errors       = 0;
        compares         = 0;
        d                = 32'h0;
        reset            = 1'b1;
        reg_addr         = 8'h00;
        reg_wdata        = 32'h0;
        reg_wr           = 1'b0;
        reg_rd           = 1'b0;
        link_up          = 1'b0;
        link_speed       = SPD_10;
        link_full_duplex = 1'b0;
        eee_agreed       = 1'b0;
        tick(3);
        reset <= 1'b0;
        t_reset();
        t_gating();
        t_entry();
        t_wake();
        finish_test();
    end
endmodule : eee_rx_lpi_decoder_tb

// ==== test/eerx_phy_model.sv ====
/*
 * Receive side of a PHY: makes the receive clock and LPI or idle codes.
 * Assumes the bench calls send; the clock stands still between calls.
 */
`timescale 1ns/100ps
`include "eerx_defs.svh"

module eerx_phy_model
(
    // Receive byte interface
    output logic       rx_clk,
    output logic [7:0] rxd,
    output logic       rx_dv,
    output logic       rx_er
);
    initial
    begin
        rx_clk = 1'b0;
        rxd    = 8'h00;
        rx_dv  = 1'b0;
        rx_er  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sends n clocks of LPI or idle; a stop follows 9 or more LPI
    // clocks and a restart gives at least 1 LPI clock first
    task send(input bit lpi, input int n);
        for (int i = 0; i < n; i++)
        begin
            rxd   = lpi ? `EERX_LPI_RXD : 8'h00;
            rx_er = lpi;
            #62.5 rx_clk = 1'b1;
            #62.5 rx_clk = 1'b0;
        end
    endtask : send
endmodule : eerx_phy_model
